// >>> pkg/ctd_pkg.sv
// Constants shared by the current tamper detector
package ctd_pkg;
  // Line-period schedule (counter values at period start)
  localparam logic [5:0] CTD_HOLD_START = 6'd24;
  localparam logic [5:0] CTD_HOLD_END   = 6'd39;
  localparam logic [5:0] CTD_MUX_END    = 6'd31;
  localparam logic [5:0] CTD_WIN1_START = 6'd28;
  localparam logic [5:0] CTD_WIN2_START = 6'd32;
  localparam logic [5:0] CTD_WIN2_END   = 6'd35;
  localparam logic [2:0] CTD_CONSEC     = 3'd4;
  // Threshold as left shift of |a-b| against |a+b|
  localparam int         CTD_SHIFT_12P5 = 4;
  localparam int         CTD_SHIFT_6P25 = 5;
  localparam int         CTD_ENERGY_W   = 32;
  // APB map
  localparam logic [7:0] CTD_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] CTD_ADDR_STATUS = 8'h04;
  localparam logic [7:0] CTD_ADDR_EN_A   = 8'h08;
  localparam logic [7:0] CTD_ADDR_EN_B   = 8'h0C;
  // Control fields
  localparam int CTD_CTRL_ENABLE = 0;
  localparam int CTD_CTRL_THRSEL = 1;
  localparam int CTD_CTRL_STANDALONE = 2;
  localparam logic [2:0] CTD_CTRL_RESET = 3'b000;
  // Status fields
  localparam int CTD_ST_TAMPER   = 0;
  localparam int CTD_ST_MUX      = 1;
  localparam int CTD_ST_HOLD     = 2;
  localparam int CTD_ST_FINALSEC = 3;
  localparam int CTD_ST_DISABLED = 4;
  localparam int CTD_ST_CNT_LSB  = 8;
  localparam int CTD_ST_CONS_LSB = 16;
endpackage : ctd_pkg

// >>> logic/ctd_energy_acc.sv
// Windowed signed energy accumulator
`timescale 1ns/1ps
`default_nettype none
module ctd_energy_acc #(
  parameter int SW = 24,
  parameter int AW = 32
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 clear,
  input  wire logic                 add_en,
  input  wire logic signed [SW-1:0] sample,
  output logic signed [AW-1:0]      acc
);
  logic signed [AW-1:0] acc_reg;
  logic signed [AW-1:0] acc_next;
  wire  signed [AW-1:0] sample_ext = {{(AW-SW){sample[SW-1]}}, sample};

  assign acc_next = clear ? '0 : (add_en ? acc_reg + sample_ext : acc_reg);
  assign acc      = acc_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) acc_reg <= '0;
    else        acc_reg <= acc_next;
  end
endmodule : ctd_energy_acc
`default_nettype wire

// >>> logic/ctd_criterion.sv
// Tamper criterion on two energy samples
`timescale 1ns/1ps
`default_nettype none
module ctd_criterion #(
  parameter int AW = 32
) (
  input  wire logic signed [AW-1:0] energy_a,
  input  wire logic signed [AW-1:0] energy_b,
  input  wire logic                 thr_sel,
  output logic                      threshold_select_bit,
  output logic                      opposite,
  output logic                      a_bigger
);
  import ctd_pkg::*;

  function automatic logic [AW:0] ctd_abs(input logic signed [AW:0] v);
    ctd_abs = v[AW] ? $unsigned(-v) : $unsigned(v);
  endfunction : ctd_abs

  wire signed [AW:0] a_ext  = {energy_a[AW-1], energy_a};
  wire signed [AW:0] b_ext  = {energy_b[AW-1], energy_b};
  wire        [AW:0] abs_d  = ctd_abs(a_ext - b_ext);
  wire        [AW:0] abs_s  = ctd_abs(a_ext + b_ext);
  wire        [AW+5:0] d_ext = {5'd0, abs_d};
  wire        [AW+5:0] s_ext = {5'd0, abs_s};
  // |a-b| > k*(a+b)/2  <=>  |a-b| << shift > |a+b|
  wire        [AW+5:0] d_hi = d_ext << CTD_SHIFT_12P5;
  wire        [AW+5:0] d_lo = d_ext << CTD_SHIFT_6P25;
  wire                 nz   = (energy_a != '0) && (energy_b != '0);

  assign opposite = nz && (energy_a[AW-1] ^ energy_b[AW-1]);
  assign threshold_select_bit     = opposite || ((thr_sel ? d_lo : d_hi) > s_ext);
  assign a_bigger = ctd_abs(a_ext) > ctd_abs(b_ext);
endmodule : ctd_criterion
`default_nettype wire

// >>> logic/ctd_top.sv
// Live/neutral current tamper detector with APB registers
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctd_top
  import ctd_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 line_slope_sign,
  input  wire logic                 line_freq_range_error,
  input  wire logic                 stream_stuck,
  input  wire logic                 no_load_flag,
  input  wire logic                 power_valid,
  input  wire logic signed [SAMPLE_W-1:0] power_sample,
  output logic                      channel_select_signal,
  output logic                      hold_primary_values,
  output logic                      final_secondary,
  output logic                      tamper_flag,
  output logic                      standalone_data_pin
);
  import ctd_pkg::*;

  typedef enum logic [1:0] {
    CTD_NORMAL = 2'b01,
    CTD_TAMPER = 2'b10
  } ctd_state_e;

  // Registers
  logic [2:0]  ctrl_reg;
  logic        slope_prev_reg;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic [2:0]  consec_reg;
  logic [2:0]  consec_next;
  ctd_state_e  state_reg;
  ctd_state_e  state_next;
  logic        final_sec_reg;
  logic        final_sec_next;
  logic        mux_reg;
  logic        hold_reg;
  logic        pin_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  // Control and events
  wire tamper_en  = ctrl_reg[CTD_CTRL_ENABLE];
  wire thr_sel    = ctrl_reg[CTD_CTRL_THRSEL];
  wire standalone = ctrl_reg[CTD_CTRL_STANDALONE];
  wire disabled   = !tamper_en || line_freq_range_error || stream_stuck
                    || no_load_flag;
  wire period_tick = slope_prev_reg && !line_slope_sign;

  // Schedule decode from the period counter
  wire in_hold  = (cnt_reg >= CTD_HOLD_START) && (cnt_reg <= CTD_HOLD_END);
  wire in_other = (cnt_reg >= CTD_HOLD_START) && (cnt_reg <= CTD_MUX_END);
  wire in_win1  = (cnt_reg >= CTD_WIN1_START) && (cnt_reg < CTD_WIN2_START);
  wire in_win2  = (cnt_reg >= CTD_WIN2_START) && (cnt_reg <= CTD_WIN2_END);
  wire acc_clr  = disabled || (cnt_reg == CTD_HOLD_START);
  wire eval     = !disabled && period_tick && (cnt_reg == CTD_WIN2_END);

  // Window 1 holds the non-final channel, window 2 the final one
  logic signed [CTD_ENERGY_W-1:0] win1;
  logic signed [CTD_ENERGY_W-1:0] win2;
  wire  signed [CTD_ENERGY_W-1:0] energy_a = final_sec_reg ? win1 : win2;
  wire  signed [CTD_ENERGY_W-1:0] energy_b = final_sec_reg ? win2 : win1;
  logic threshold_select_bit;
  logic opposite;
  logic a_bigger;

  ctd_energy_acc #(.SW(SAMPLE_W), .AW(CTD_ENERGY_W)) u_acc_win1 (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (acc_clr),
    .add_en  (power_valid && in_win1),
    .sample  (power_sample),
    .acc     (win1)
  );

  ctd_energy_acc #(.SW(SAMPLE_W), .AW(CTD_ENERGY_W)) u_acc_win2 (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (acc_clr),
    .add_en  (power_valid && in_win2),
    .sample  (power_sample),
    .acc     (win2)
  );

  ctd_criterion #(.AW(CTD_ENERGY_W)) u_threshold_select_bit (
    .energy_a (energy_a),
    .energy_b (energy_b),
    .thr_sel  (thr_sel),
    .threshold_select_bit     (threshold_select_bit),
    .opposite (opposite),
    .a_bigger (a_bigger)
  );

  // Period counter
  assign cnt_next = disabled ? 6'd0 :
                    (period_tick ? cnt_reg + 6'd1 : cnt_reg);

  // Decision logic
  always_comb begin
    consec_next    = consec_reg;
    state_next     = state_reg;
    final_sec_next = final_sec_reg;
    if (disabled) begin
      consec_next    = 3'd0;
      state_next     = CTD_NORMAL;
      final_sec_next = 1'b0;
    end else if (eval) begin
      case (state_reg)
        CTD_NORMAL: begin
          if (threshold_select_bit) begin
            consec_next = (consec_reg < CTD_CONSEC) ? consec_reg + 3'd1 : consec_reg;
            if (opposite || consec_next == CTD_CONSEC) begin
              state_next     = CTD_TAMPER;
              final_sec_next = !a_bigger;
            end
          end else begin
            consec_next = 3'd0;
          end
        end
        CTD_TAMPER: begin
          if (threshold_select_bit) begin
            final_sec_next = !a_bigger;
          end else begin
            consec_next    = 3'd0;
            state_next     = CTD_NORMAL;
            final_sec_next = 1'b0;
          end
        end
        default: begin
          state_next     = CTD_NORMAL;
          final_sec_next = 1'b0;
        end
      endcase
    end
  end

  // APB decode
  wire apb_access = psel && penable && pready_reg;
  wire apb_wr     = apb_access && pwrite;
  wire hit_ctrl   = (paddr == CTD_ADDR_CTRL);
  wire hit_status = (paddr == CTD_ADDR_STATUS);
  wire hit_en_a   = (paddr == CTD_ADDR_EN_A);
  wire hit_en_b   = (paddr == CTD_ADDR_EN_B);
  wire mapped     = hit_ctrl || hit_status || hit_en_a || hit_en_b;
  wire ro_write   = pwrite && !hit_ctrl;

  logic [31:0] status_word;
  logic [31:0] rdata_mux;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[CTD_ST_TAMPER]   = tamper_flag;
    status_word[CTD_ST_MUX]      = mux_reg;
    status_word[CTD_ST_HOLD]     = hold_reg;
    status_word[CTD_ST_FINALSEC] = final_sec_reg;
    status_word[CTD_ST_DISABLED] = disabled;
    status_word[CTD_ST_CNT_LSB +: 6]  = cnt_reg;
    status_word[CTD_ST_CONS_LSB +: 3] = consec_reg;
  end

  assign rdata_mux = hit_ctrl   ? {29'd0, ctrl_reg} :
                     hit_status ? status_word :
                     hit_en_a   ? energy_a :
                     hit_en_b   ? energy_b : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && (!mapped || ro_write);
      if (psel && penable && !pready_reg && !pwrite) prdata_reg <= rdata_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) ctrl_reg <= CTD_CTRL_RESET;
    else if (apb_wr && hit_ctrl) ctrl_reg <= pwdata[2:0];
  end

  // Core state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      slope_prev_reg <= 1'b0;
      cnt_reg        <= 6'd0;
      consec_reg     <= 3'd0;
      state_reg      <= CTD_NORMAL;
      final_sec_reg  <= 1'b0;
    end else begin
      slope_prev_reg <= line_slope_sign;
      cnt_reg        <= cnt_next;
      consec_reg     <= consec_next;
      state_reg      <= state_next;
      final_sec_reg  <= final_sec_next;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mux_reg  <= 1'b0;
      hold_reg <= 1'b0;
      pin_reg  <= 1'b0;
    end else begin
      mux_reg  <= disabled ? 1'b0 : (final_sec_reg ^ in_other);
      hold_reg <= !disabled && in_hold;
      pin_reg  <= standalone && (state_next == CTD_TAMPER);
    end
  end

  assign channel_select_signal = mux_reg;
  assign hold_primary_values   = hold_reg;
  assign final_secondary       = final_sec_reg;
  assign tamper_flag           = (state_reg == CTD_TAMPER);
  assign standalone_data_pin   = pin_reg;
  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;

  // Checks
  sequence s_hold_start;
    !disabled && (cnt_reg == CTD_HOLD_START);
  endsequence

  sequence s_enter;
    eval && !tamper_flag && (state_next == CTD_TAMPER);
  endsequence

  chk_reset_normal: assert property (@(posedge clk_sys) !rst_b |=> !tamper_flag && !final_secondary && !channel_select_signal)
    else $error("state not normal after reset");

  chk_disable_forces: assert property (@(posedge clk_sys) disable iff (!rst_b) disabled |=> cnt_reg == 6'd0 && !tamper_flag && !final_secondary)
    else $error("disable did not force normal");

  chk_noload_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) no_load_flag |=> !hold_primary_values)
    else $error("hold active during no-load");

  chk_hold_start: assert property (@(posedge clk_sys) disable iff (!rst_b) s_hold_start |=> hold_primary_values && (channel_select_signal != final_secondary))
    else $error("hold or switch missing at period 24");

  chk_mux_in_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) (channel_select_signal != final_secondary) |-> hold_primary_values)
    else $error("other channel selected outside hold");

  chk_count_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b) !disabled && period_tick && cnt_reg == 6'd63 |=> cnt_reg == 6'd0)
    else $error("period counter did not wrap at 64");

  chk_entry_count: assert property (@(posedge clk_sys) disable iff (!rst_b) s_enter |-> opposite || consec_reg == CTD_CONSEC - 3'd1)
    else $error("tamper entered before four evaluations");

  chk_enter_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) s_enter |=> tamper_flag && (final_secondary == !$past(a_bigger)))
    else $error("tamper entry did not select larger channel");

  chk_pin_follows: assert property (@(posedge clk_sys) disable iff (!rst_b) standalone && !$rose(standalone) |-> standalone_data_pin == tamper_flag)
    else $error("standalone pin differs from tamper flag");

  chk_mux_back: assert property (@(posedge clk_sys) disable iff (!rst_b) !disabled && cnt_reg == CTD_WIN2_START |=> channel_select_signal == final_secondary)
    else $error("channel not switched back at period 32");

  chk_pin_off: assert property (@(posedge clk_sys) disable iff (!rst_b) !standalone |=> !standalone_data_pin)
    else $error("standalone pin driven outside standalone mode");

  chk_opp_enter: assert property (@(posedge clk_sys) disable iff (!rst_b) eval && opposite |=> tamper_flag)
    else $error("opposite signs did not force tamper");

  chk_acc_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) disabled |=> win1 == '0 && win2 == '0)
    else $error("energy windows not cleared while disabled");

  chk_tick_count: assert property (@(posedge clk_sys) disable iff (!rst_b) !disabled && !period_tick |=> cnt_reg == $past(cnt_reg))
    else $error("period counter moved without a line tick");

  chk_ready_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b) pready |=> !pready)
    else $error("ready held longer than one cycle");
endmodule : ctd_top
`default_nettype wire

// >>> testbench/ctd_far_end.sv
// Line-period and power-sample source facing the tamper detector
`timescale 1ns/1ps
`default_nettype none
module ctd_far_end #(
  parameter int HALF = 12
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               channel_select_signal,
  input  wire logic signed [23:0] p_pri,
  input  wire logic signed [23:0] p_sec,
  output logic                    line_slope_sign,
  output logic                    power_valid,
  output logic signed [23:0]      power_sample
);
  int ph_reg;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ph_reg          <= 0;
      line_slope_sign <= 1'b0;
      power_valid     <= 1'b0;
      power_sample    <= 24'h00_0000;
    end else begin
      // Falling slope sign ends one line period
      ph_reg <= (ph_reg == HALF - 1) ? 0 : ph_reg + 1;
      if (ph_reg == HALF - 1) line_slope_sign <= ~line_slope_sign;
      // Valid on alternate cycles, garbage in between
      power_valid  <= ~power_valid;
      power_sample <= power_valid ? ~power_sample : (channel_select_signal ? p_sec : p_pri);
    end
  end
endmodule : ctd_far_end
`default_nettype wire

// >>> testbench/current_tamper_detector_test.sv
// Self-checking bench for the current tamper detector
`timescale 1ns/1ps
`default_nettype none
module current_tamper_detector_test;
  import ctd_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} ctd_note_s;
  logic               clk_sys = 1'b0, rst_b = 1'b0;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000, prdata, rnd;
  logic               pready, pslverr, line_slope_sign, power_valid;
  logic               lfre = 1'b0, stream_stuck = 1'b0, no_load_flag = 1'b0;
  logic signed [23:0] power_sample, p_pri = 24'sd0, p_sec = 24'sd0;
  logic               css, hold, fsec, tflag, sdp, sched = 1'b0;
  int                 fails = 0, samples_checked = 0, tcnt = 0, seed;
  ctd_note_s          notes[$];
  ctd_note_s          nt;
  int                 pp[5] = '{1000, 1000, 800, 1000, 1000};
  int                 ps[5] = '{1000, 800, 1000, 920, 920};
  logic [4:0]         et = 5'b10110, ef = 5'b00100, thr = 5'b10000;

  always #25 clk_sys = ~clk_sys;

  ctd_top #(.SAMPLE_W(24)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_slope_sign(line_slope_sign),
    .line_freq_range_error(lfre), .stream_stuck(stream_stuck), .no_load_flag(no_load_flag),
    .power_valid(power_valid), .power_sample(power_sample), .channel_select_signal(css),
    .hold_primary_values(hold), .final_secondary(fsec), .tamper_flag(tflag),
    .standalone_data_pin(sdp));
  ctd_far_end #(.HALF(12)) far_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .channel_select_signal(css), .p_pri(p_pri), .p_sec(p_sec),
    .line_slope_sign(line_slope_sign), .power_valid(power_valid),
    .power_sample(power_sample));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Completed transfers judged against the oldest note
  always @(posedge clk_sys) begin
    if (pready === 1'b1) begin
      nt = notes.pop_front();
      chk("prdata", prdata & nt.mask, nt.exp);
      chk("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic [31:0] mask, input logic err);
    int n;
    notes.push_back('{exp, mask, err});
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready timeout", 32'h0, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ticks(input int n);
    int c;
    repeat (n) begin
      @(negedge line_slope_sign);
      tcnt++;
      repeat (6) @(posedge clk_sys);
      c = tcnt % 64;
      if (sched) begin
        chk("hold", hold, c >= 24 && c <= 39);
        chk("mux", css, c >= 24 && c <= 31);
        chk("final", fsec, 0);
      end
    end
  endtask : ticks

  task automatic set_case(input int a, input int b, input logic th, input logic sa);
    apb(1, CTD_ADDR_CTRL, 32'h0000_0000, 0, 0, 0);
    p_pri <= 24'(a + ($random(seed) & 7));
    p_sec <= 24'(b + ($random(seed) & 7));
    rnd = $random(seed);
    // Enable just after a line tick so no tick slips past the counter reset
    @(negedge line_slope_sign);
    apb(1, CTD_ADDR_CTRL, {rnd[31:3], sa, th, 1'b1}, 0, 0, 0);
    tcnt = 0;
    apb(0, CTD_ADDR_CTRL, 0, {29'h0, sa, th, 1'b1}, 32'hFFFF_FFFF, 0);
  endtask : set_case

  initial begin
    seed = 32'h2bf2;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk("outputs", {css, hold, fsec, tflag, sdp}, 0);
    apb(0, CTD_ADDR_CTRL, 0, 0, 32'hFFFF_FFFF, 0);
    apb(0, CTD_ADDR_STATUS, 0, 32'h0000_0010, 32'h0007_3F1F, 0);
    apb(0, 8'h40, 0, 0, 32'hFFFF_FFFF, 1);
    apb(1, CTD_ADDR_STATUS, 32'h0000_0001, 0, 0, 1);
    $display("test reset_and_map done");
    for (int k = 0; k < 3; k++) begin
      set_case(1000, -500, 0, 0);
      ticks(40);
      chk("opposite tamper", tflag, 1);
      {lfre, stream_stuck, no_load_flag} <= 3'b100 >> k;
      repeat (3) @(posedge clk_sys);
      chk("forced normal", {tflag, css, hold, fsec}, 0);
      ticks(30);
      chk("held disabled", {tflag, css, hold, fsec}, 0);
      {lfre, stream_stuck, no_load_flag} <= 3'b000;
    end
    $display("test disable_inputs done");
    for (int k = 0; k < 5; k++) begin
      set_case(pp[k], ps[k], thr[k], k[0]);
      sched = (k == 0);
      ticks(3 * 64 + 30);
      sched = 1'b0;
      chk("early tamper", tflag, 0);
      ticks(10);
      chk("tamper", tflag, et[k]);
      chk("final", fsec, ef[k]);
      chk("pin", sdp, et[k] & k[0]);
      apb(0, CTD_ADDR_STATUS, 0, {18'h0, 6'd40, 4'h0, ef[k], 2'b00, et[k]},
          32'h0000_3F09, 0);
      ticks(28);
      chk("mux outside", css, ef[k]);
      ticks(24);
      chk("mux window", css, !ef[k]);
      chk("hold window", hold, 1);
      $display("test case %0d done", k);
    end
    tally_and_finish();
  end

  initial begin
    #(50 * 80000);
    fails++;
    tally_and_finish();
  end
endmodule : current_tamper_detector_test
`default_nettype wire
